// file: temp_prot_defs.vh
`ifndef TEMP_PROT_DEFS_VH
`define TEMP_PROT_DEFS_VH

// APB address width and register byte offsets
`define ADDR_W          8
`define OFS_FET_OT      8'h00
`define OFS_DIE_OT      8'h04
`define OFS_CHG_UT      8'h08
`define OFS_DSG_UT      8'h0C
`define OFS_DIE_UT      8'h10
`define OFS_REC_TIME    8'h14
`define OFS_HOST_WD     8'h18
`define OFS_FAULT       8'h1C
`define OFS_INT_STATUS  8'h20
`define OFS_INT_MASK    8'h24

// Limit register fields: trip threshold, recovery threshold, trip delay
`define LIM_TRIP_LSB    0
`define LIM_REC_LSB     8
`define LIM_DLY_LSB     16
`define LIM_W           24

// Limit register reset values {delay, recovery, trip}
`define RST_FET_OT      24'h024150
`define RST_DIE_OT      24'h025055
`define RST_CHG_UT      24'h020500
`define RST_DSG_UT      24'h020500
`define RST_DIE_UT      24'h02F1EC
`define RST_REC_TIME    8'h03
`define RST_HOST_WD     16'h003C
`define RST_INT_MASK    6'h3F

// Fault bit positions in fault, status and mask registers
`define FLT_FET_OT      0
`define FLT_DIE_OT      1
`define FLT_CHG_UT      2
`define FLT_DSG_UT      3
`define FLT_DIE_UT      4
`define FLT_HOST        5
`define FLT_N           6
`define LIM_N           5

// Temperature input width, signed degrees Celsius
`define TEMP_W          16

`endif

// file: fault_persist.v
`timescale 1ns/1ps

module fault_persist
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       sec_tick,
  input  wire       trip_cond,
  input  wire       rec_cond,
  input  wire [7:0] trip_delay,
  input  wire [7:0] rec_time,
  output reg        fault
);

  reg  [7:0] secs;
  wire       cond;
  wire [7:0] limit;

  // Watch trip while clear, recovery while set
  assign cond  = fault ? rec_cond : trip_cond;
  assign limit = fault ? rec_time : trip_delay;

  ////////////////////////////////////////////////////////////////////
  // Persistence counter and fault flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secs  <= 8'h00;
      fault <= 1'b0;
    end
    else if (!cond)
      secs <= 8'h00;
    else if (secs >= limit)
    begin
      fault <= ~fault;
      secs  <= 8'h00;
    end
    else if (sec_tick)
      secs <= secs + 8'h01;
  end

endmodule

// file: host_silence_timer.v
`timescale 1ns/1ps

module host_silence_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        sec_tick,
  input  wire        comm_rx,
  input  wire [15:0] silence_limit,
  output reg         fault
);

  reg [15:0] secs;

  ////////////////////////////////////////////////////////////////////
  // Silence counter; any host traffic restarts it and clears the fault
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secs  <= 16'h0000;
      fault <= 1'b0;
    end
    else if (comm_rx || silence_limit == 16'h0000)
    begin
      secs  <= 16'h0000;
      fault <= 1'b0;
    end
    else if (secs >= silence_limit)
      fault <= 1'b1;
    else if (sec_tick)
      secs <= secs + 16'h0001;
  end

endmodule

// file: temp_protection_watchdog.v
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "temp_prot_defs.vh"

module temp_protection_watchdog
(
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`ADDR_W-1:0]     paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire                   sec_tick,
  input  wire                   comm_rx,
  input  wire signed [`TEMP_W-1:0] fet_temp,
  input  wire signed [`TEMP_W-1:0] die_temp,
  input  wire signed [`TEMP_W-1:0] cell_min_temp,
  output wire                   fet_overtemp_fault,
  output wire                   die_overtemp_fault,
  output wire                   charge_undertemp_fault,
  output wire                   discharge_undertemp_fault,
  output wire                   die_undertemp_fault,
  output wire                   host_silence_fault,
  output wire                   irq
);

  ////////////////////////////////////////////////////////////////////
  // Storage

  reg  [`LIM_W-1:0]  limits [0:`LIM_N-1];
  reg  [7:0]         rec_time;
  reg  [15:0]        host_limit;
  reg  [`FLT_N-1:0]  int_status;
  reg  [`FLT_N-1:0]  int_mask;
  reg  [`FLT_N-1:0]  fault_seen;
  wire [`FLT_N-1:0]  faults;
  wire [`FLT_N-1:0]  fault_rise;
  wire [`FLT_N-1:0]  w1c_bits;
  reg  [`LIM_N-1:0]  trip_vec;
  reg  [`LIM_N-1:0]  rec_vec;
  reg  [31:0]        next_prdata;
  reg                mapped;
  wire               wr_en;
  wire               setup;
  wire [2:0]         lim_idx;
  wire               lim_hit;

  ////////////////////////////////////////////////////////////////////
  // APB handshake: zero wait states, error on unmapped offsets

  assign setup   = psel & ~penable;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & mapped;

  // Limit registers occupy the first five words
  assign lim_idx = paddr[4:2];
  assign lim_hit = (paddr < `OFS_REC_TIME) && (paddr[1:0] == 2'b00);

  // Address decode
  always @*
  begin
    case (paddr)
      `OFS_FET_OT,
      `OFS_DIE_OT,
      `OFS_CHG_UT,
      `OFS_DSG_UT,
      `OFS_DIE_UT,
      `OFS_REC_TIME,
      `OFS_HOST_WD,
      `OFS_FAULT,
      `OFS_INT_STATUS,
      `OFS_INT_MASK: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration writes

  // Limit words, recovery time, silence limit and mask
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limits[`FLT_FET_OT] <= `RST_FET_OT;
      limits[`FLT_DIE_OT] <= `RST_DIE_OT;
      limits[`FLT_CHG_UT] <= `RST_CHG_UT;
      limits[`FLT_DSG_UT] <= `RST_DSG_UT;
      limits[`FLT_DIE_UT] <= `RST_DIE_UT;
      rec_time            <= `RST_REC_TIME;
      host_limit          <= `RST_HOST_WD;
      int_mask            <= `RST_INT_MASK;
    end
    else if (wr_en)
    begin
      if (lim_hit)
        limits[lim_idx] <= pwdata[`LIM_W-1:0];
      if (paddr == `OFS_REC_TIME)
        rec_time <= pwdata[7:0];
      if (paddr == `OFS_HOST_WD)
        host_limit <= pwdata[15:0];
      if (paddr == `OFS_INT_MASK)
        int_mask <= pwdata[`FLT_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle

  always @*
  begin
    next_prdata = 32'h0000_0000;
    if (lim_hit)
      next_prdata = {8'h00, limits[lim_idx]};
    else
    begin
      case (paddr)
        `OFS_REC_TIME:   next_prdata = {24'h00_0000, rec_time};
        `OFS_HOST_WD:    next_prdata = {16'h0000, host_limit};
        `OFS_FAULT:      next_prdata = {26'h000_0000, faults};
        `OFS_INT_STATUS: next_prdata = {26'h000_0000, int_status};
        `OFS_INT_MASK:   next_prdata = {26'h000_0000, int_mask};
        default:         next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= next_prdata;
  end

  ////////////////////////////////////////////////////////////////////
  // Threshold comparisons, all in signed degrees

  // FET limits are unsigned bytes, the rest signed bytes
  always @*
  begin
    trip_vec[`FLT_FET_OT] = fet_temp >=
      $signed({8'h00, limits[`FLT_FET_OT][`LIM_TRIP_LSB+:8]});
    rec_vec[`FLT_FET_OT] = fet_temp <=
      $signed({8'h00, limits[`FLT_FET_OT][`LIM_REC_LSB+:8]});
    trip_vec[`FLT_DIE_OT] = die_temp >=
      $signed({{8{limits[`FLT_DIE_OT][7]}},
               limits[`FLT_DIE_OT][`LIM_TRIP_LSB+:8]});
    rec_vec[`FLT_DIE_OT] = die_temp <=
      $signed({{8{limits[`FLT_DIE_OT][15]}},
               limits[`FLT_DIE_OT][`LIM_REC_LSB+:8]});
    trip_vec[`FLT_CHG_UT] = cell_min_temp <=
      $signed({{8{limits[`FLT_CHG_UT][7]}},
               limits[`FLT_CHG_UT][`LIM_TRIP_LSB+:8]});
    rec_vec[`FLT_CHG_UT] = cell_min_temp >=
      $signed({{8{limits[`FLT_CHG_UT][15]}},
               limits[`FLT_CHG_UT][`LIM_REC_LSB+:8]});
    trip_vec[`FLT_DSG_UT] = cell_min_temp <=
      $signed({{8{limits[`FLT_DSG_UT][7]}},
               limits[`FLT_DSG_UT][`LIM_TRIP_LSB+:8]});
    rec_vec[`FLT_DSG_UT] = cell_min_temp >=
      $signed({{8{limits[`FLT_DSG_UT][15]}},
               limits[`FLT_DSG_UT][`LIM_REC_LSB+:8]});
    trip_vec[`FLT_DIE_UT] = die_temp <=
      $signed({{8{limits[`FLT_DIE_UT][7]}},
               limits[`FLT_DIE_UT][`LIM_TRIP_LSB+:8]});
    rec_vec[`FLT_DIE_UT] = die_temp >=
      $signed({{8{limits[`FLT_DIE_UT][15]}},
               limits[`FLT_DIE_UT][`LIM_REC_LSB+:8]});
  end

  ////////////////////////////////////////////////////////////////////
  // Persistence filters, one per temperature fault

  genvar g;
  generate
    for (g = 0; g < `LIM_N; g = g + 1)
    begin : persist
      fault_persist u_persist
      (
        .pclk       (pclk),
        .presetn    (presetn),
        .sec_tick   (sec_tick),
        .trip_cond  (trip_vec[g]),
        .rec_cond   (rec_vec[g]),
        .trip_delay (limits[g][`LIM_DLY_LSB+:8]),
        .rec_time   (rec_time),
        .fault      (faults[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Host watchdog

  host_silence_timer u_host_wd
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .sec_tick      (sec_tick),
    .comm_rx       (comm_rx),
    .silence_limit (host_limit),
    .fault         (faults[`FLT_HOST])
  );

  ////////////////////////////////////////////////////////////////////
  // Fault outputs

  assign fet_overtemp_fault        = faults[`FLT_FET_OT];
  assign die_overtemp_fault        = faults[`FLT_DIE_OT];
  assign charge_undertemp_fault    = faults[`FLT_CHG_UT];
  assign discharge_undertemp_fault = faults[`FLT_DSG_UT];
  assign die_undertemp_fault       = faults[`FLT_DIE_UT];
  assign host_silence_fault        = faults[`FLT_HOST];

  ////////////////////////////////////////////////////////////////////
  // Interrupts: sticky on each fault rising, write one to clear

  assign fault_rise = faults & ~fault_seen;
  assign w1c_bits   = (wr_en && paddr == `OFS_INT_STATUS) ?
                      pwdata[`FLT_N-1:0] : {`FLT_N{1'b0}};

  // A rise in the clearing cycle survives the clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_seen <= {`FLT_N{1'b0}};
      int_status <= {`FLT_N{1'b0}};
    end
    else
    begin
      fault_seen <= faults;
      int_status <= (int_status & ~w1c_bits) | fault_rise;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(int_status & int_mask);

endmodule

// file: host_model.sv
`timescale 1ns/1ps

module host_model
(
  input  wire pclk,
  input  wire presetn,
  input  wire talk,
  output reg  comm_rx
);
  reg [1:0] cnt;

  // Host traffic: one frame every four cycles while talking, silent otherwise
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt     <= 2'h0;
      comm_rx <= 1'b0;
    end
    else
    begin
      cnt     <= cnt + 2'h1;
      comm_rx <= talk && (cnt == 2'h3);
    end
  end
endmodule

// file: temp_prot_monitor.sv
`timescale 1ns/1ps

module temp_prot_monitor
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sec_tick,
  input wire        comm_rx,
  input wire [5:0]  flt,
  input wire        irq
);
  wire       acc = psel && penable;
  wire       rda = acc && !pwrite;
  wire       map = (paddr <= 8'h24) && (paddr[1:0] == 2'h0);
  wire       tk;
  reg  [5:0] flt_q;
  reg        rise_q;
  reg        tick_d1;
  reg        tick_d2;

  // A second tick seen at either of the last two edges
  assign tk = tick_d1 || tick_d2;

  // Remember a fault rise one cycle, the cause of a status bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flt_q   <= 6'h00;
      rise_q  <= 1'b0;
      tick_d1 <= 1'b0;
      tick_d2 <= 1'b0;
    end
    else
    begin
      flt_q   <= flt;
      rise_q  <= |(flt & ~flt_q);
      tick_d1 <= sec_tick;
      tick_d2 <= tick_d1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_high_a: assert property (acc |-> pready) else $error("pready low");
  err_map_a: assert property (acc |-> pslverr == !map) else $error("bad pslverr");
  err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  unmap_zero_a: assert property (rda && !map |-> prdata == 32'h0) else $error("bad read");
  fault_read_a: assert property (rda && paddr == 8'h1C |-> prdata == {26'h0, $past(flt)})
    else $error("fault word mismatch");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc && pwrite)) else $error("irq fell");
  irq_rise_a: assert property ($rose(irq) |-> rise_q || $past(acc && pwrite))
    else $error("irq rose");
  host_fall_a: assert property ($fell(flt[5]) |-> $past(comm_rx)) else $error("host fell");
  host_rise_a: assert property ($rose(flt[5]) |-> tk && !$past(comm_rx))
    else $error("host rose");
  temp_step_a: assert property (flt[4:0] != $past(flt[4:0]) |-> tk)
    else $error("fault moved without tick");

  cover property ($rose(flt[0]));
  cover property ($fell(flt[5]));
  cover property ($rose(irq));
endmodule

bind temp_protection_watchdog temp_prot_monitor mon
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sec_tick(sec_tick), .comm_rx(comm_rx), .irq(irq),
  .flt({host_silence_fault, die_undertemp_fault, discharge_undertemp_fault,
        charge_undertemp_fault, die_overtemp_fault, fet_overtemp_fault})
);

// file: testbench.sv
`timescale 1ns/1ps
`include "temp_prot_defs.vh"

module testbench;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  wire  [31:0]        prdata;
  wire                pready;
  wire                pslverr;
  logic               sec_tick;
  wire                comm_rx;
  logic               talk;
  logic signed [15:0] fet_temp;
  logic signed [15:0] die_temp;
  logic signed [15:0] cell_min_temp;
  wire  [5:0]         flt;
  wire                irq;
  logic [31:0]        rd;
  logic [31:0]        rv;
  logic               er;
  integer             seed;
  integer             fail_count;
  integer             comparisons;
  integer             cycles;
  wire  [31:0]        tf = {27'h0, flt[4:0]};

  temp_protection_watchdog dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sec_tick(sec_tick), .comm_rx(comm_rx), .fet_temp(fet_temp), .die_temp(die_temp),
    .cell_min_temp(cell_min_temp), .fet_overtemp_fault(flt[0]),
    .die_overtemp_fault(flt[1]), .charge_undertemp_fault(flt[2]),
    .discharge_undertemp_fault(flt[3]), .die_undertemp_fault(flt[4]),
    .host_silence_fault(flt[5]), .irq(irq)
  );

  host_model hm (.pclk(pclk), .presetn(presetn), .talk(talk), .comm_rx(comm_rx));

  ////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      summarize;
    end
  end

  task summarize;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task tick;
    @(posedge pclk);
    sec_tick <= 1'b1;
    @(posedge pclk);
    sec_tick <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task st(input int s, input int v);
    case (s)
      0: fet_temp <= v[15:0];
      1: die_temp <= v[15:0];
      default: cell_min_temp <= v[15:0];
    endcase
  endtask

  // A temperature that neither trips nor blocks recovery
  function int neut;
    neut = 10 + {$random(seed)} % 50;
  endfunction

  function logic [31:0] rst(input logic [7:0] a);
    case (a)
      `OFS_FET_OT: rst = {8'h0, `RST_FET_OT};
      `OFS_DIE_OT: rst = {8'h0, `RST_DIE_OT};
      `OFS_CHG_UT: rst = {8'h0, `RST_CHG_UT};
      `OFS_DSG_UT: rst = {8'h0, `RST_DSG_UT};
      `OFS_DIE_UT: rst = {8'h0, `RST_DIE_UT};
      `OFS_REC_TIME: rst = {24'h0, `RST_REC_TIME};
      `OFS_HOST_WD: rst = {16'h0, `RST_HOST_WD};
      `OFS_INT_MASK: rst = {26'h0, `RST_INT_MASK};
      default: rst = 32'h0;
    endcase
  endfunction

  // Trip after two ticks, restart on a break, recover after three
  task persist(input int s, input logic [31:0] m, input int t, input int r, input int n);
    st(s, t);
    tick;
    chk(tf, 32'h0);
    st(s, neut());
    tick;
    st(s, t);
    tick;
    chk(tf, 32'h0);
    tick;
    chk(tf, m);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_INT_STATUS, m);
    chk({31'h0, irq}, 32'h0);
    st(s, n);
    repeat (3) tick;
    chk(tf, m);
    st(s, r);
    repeat (2) tick;
    chk(tf, m);
    tick;
    chk(tf, 32'h0);
    st(s, neut());
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 32'h562BC431;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    {presetn, psel, penable, pwrite, sec_tick} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    talk = 1'b1;
    fet_temp = 16'h0019;
    die_temp = 16'h0019;
    cell_min_temp = 16'h0019;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, rst(8'(i * 4)));
      chk({31'h0, er}, 32'h0);
    end
    apb(1'b1, 8'h28, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `OFS_FAULT, 32'hFFFFFFFF);
    apb(1'b0, `OFS_FAULT, 32'h0);
    chk(rd, 32'h0);
    rv = $random(seed) & 32'hFF;
    apb(1'b1, `OFS_REC_TIME, rv);
    apb(1'b0, `OFS_REC_TIME, 32'h0);
    chk(rd, rv);
    apb(1'b1, `OFS_REC_TIME, 32'h3);
    persist(0, 32'h01, 80, 65, 66);
    persist(1, 32'h02, 85, 80, 81);
    persist(2, 32'h0C, 0, 5, 4);
    persist(1, 32'h10, -20, -15, -16);
    talk <= 1'b0;
    repeat (6) @(posedge pclk);
    repeat (59) tick;
    chk({31'h0, flt[5]}, 32'h0);
    tick;
    chk({31'h0, flt[5]}, 32'h1);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    chk(rd, 32'h20);
    apb(1'b1, `OFS_INT_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `OFS_INT_MASK, 32'h3F);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_INT_STATUS, 32'h20);
    chk({31'h0, irq}, 32'h0);
    talk <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk({31'h0, flt[5]}, 32'h0);
    summarize;
  end
endmodule
